/* ipc_defs.vh */
// Purpose: Constants for the interrupt priority control block.
// Assumes: APB slave, 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.
`ifndef IPC_DEFS_VH
`define IPC_DEFS_VH

// ****************************************
// Geometry
// ****************************************
`define IPC_NSRC 8
`define IPC_NTRAP 4

// ****************************************
// Register offsets
// ****************************************
`define IPC_OFS_CTL0 12'h000
`define IPC_OFS_CTLN 12'h01c
`define IPC_OFS_TRAPFLAG 12'h020
`define IPC_OFS_EVSTAT 12'h024
`define IPC_OFS_EVCLR 12'h028
`define IPC_OFS_EVEN 12'h02c
`define IPC_OFS_STATE 12'h030

// ****************************************
// Control register fields
// ****************************************
`define IPC_CTL_IR 7
`define IPC_CTL_IE 6
`define IPC_CTL_PRIO_HI 5
`define IPC_CTL_PRIO_LO 2
`define IPC_CTL_GRP_HI 1
`define IPC_CTL_GRP_LO 0
`define IPC_CTL_RST 8'h00

// ****************************************
// Event bits
// ****************************************
`define IPC_EV_INTACK 0
`define IPC_EV_TRAPACK 1
`define IPC_EV_TRAPFLAG 2
`define IPC_NEV 3

// ****************************************
// Trap numbers and ranks
// ****************************************
`define IPC_SRC_TNUM_BASE 7'h10
`define IPC_TNUM_NMI 7'h02
`define IPC_TNUM_STKOF 7'h04
`define IPC_TNUM_STKUF 7'h06
`define IPC_TNUM_CLASSB 7'h0a
`define IPC_RANK_NONE 2'h0
`define IPC_RANK_B 2'h1
`define IPC_RANK_A 2'h2

`endif

/* ipc_arb.v */
// Purpose: Picks the winning enabled request among the sources.
// Assumes: Control bytes packed, source i in bits 8*i+7..8*i.
// Notes: Purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "ipc_defs.vh"
module ipc_arb (
	input wire [8*`IPC_NSRC-1:0] ctlFlat,
	input wire [3:0] cpuLevel,
	output reg winValid,
	output reg [2:0] winIdx
);
	// ****************************************
	// Arbitration
	// ****************************************
	reg [5:0] bestKey;
	reg [5:0] key;
	reg [7:0] c;
	integer i;
	always @* begin
		winValid = 1'b0;
		winIdx = 3'h0;
		bestKey = 6'h00;
		key = 6'h00;
		c = 8'h00;
		for (i = 0; i < `IPC_NSRC; i = i + 1) begin
			c = ctlFlat[8*i +: 8];
			// Priority above group so group only breaks ties
			key = {c[`IPC_CTL_PRIO_HI:`IPC_CTL_PRIO_LO], c[`IPC_CTL_GRP_HI:`IPC_CTL_GRP_LO]};
			// Strictly greater keeps the lowest index on a full tie
			if (c[`IPC_CTL_IR] && c[`IPC_CTL_IE]
				&& (c[`IPC_CTL_PRIO_HI:`IPC_CTL_PRIO_LO] > cpuLevel)
				&& (!winValid || key > bestKey)) begin
				winValid = 1'b1;
				winIdx = i[2:0];
				bestKey = key;
			end
		end
	end
endmodule
`default_nettype wire

/* ipc_top.v */
// Purpose: Interrupt priority control with trap handling and APB registers.
// Assumes: Sources, traps and CPU signals are on clk; no synchronisers.
// Notes: Request to the CPU is rearbitrated until cpuAck and drops if nothing wins; one idle cycle follows.
//  Traps nest one level deep; a trap return drops to no trap in service.
//  Unmapped addresses answer with pslverr and change nothing.
//  Peripheral event transfers are not handled here.
`timescale 1ns/100ps
`default_nettype none
`include "ipc_defs.vh"
module ipc_top (
	input wire clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [`IPC_NSRC-1:0] srcReq,
	input wire [`IPC_NTRAP-1:0] trapIn,
	input wire [3:0] cpuLevel,
	input wire cpuAck,
	input wire cpuTrapDone,
	output reg cpuReq,
	output reg cpuIsTrap,
	output reg [8:0] cpuVector,
	output reg irq
);
	// ****************************************
	// State
	// ****************************************
	reg [7:0] ctl_r [0:`IPC_NSRC-1];
	reg [`IPC_NTRAP-1:0] trapPend_r;
	reg [`IPC_NTRAP-1:0] trapFlag_r;
	reg [1:0] inTrapRank_r;
	reg [2:0] presIdx_r;
	reg [1:0] presTrap_r;
	reg [`IPC_NEV-1:0] evStat_r;
	reg [`IPC_NEV-1:0] evEn_r;
	wire [8*`IPC_NSRC-1:0] ctlFlat;
	wire winValid;
	wire [2:0] winIdx;
	wire apbDone;
	wire wrDone;
	wire ackInt;
	wire ackTrap;
	reg trapValid;
	reg [1:0] trapSel;
	reg [1:0] trapRank;
	reg [31:0] rdMux;
	reg rdErr;
	reg [`IPC_NEV-1:0] evSet;

	// ****************************************
	// Decoding helpers
	// ****************************************
	function isCtl;
		input [11:0] a;
		begin
			isCtl = (a >= `IPC_OFS_CTL0) && (a <= `IPC_OFS_CTLN) && (a[1:0] == 2'h0);
		end
	endfunction

	function [1:0] rankOf;
		input [1:0] t;
		begin
			rankOf = (t == 2'h3) ? `IPC_RANK_B : `IPC_RANK_A;
		end
	endfunction

	function [6:0] trapNum;
		input [1:0] t;
		begin
			case (t)
				2'h0: trapNum = `IPC_TNUM_NMI;
				2'h1: trapNum = `IPC_TNUM_STKOF;
				2'h2: trapNum = `IPC_TNUM_STKUF;
				default: trapNum = `IPC_TNUM_CLASSB;
			endcase
		end
	endfunction

	// Exact word match for the fixed registers
	function isReg;
		input [11:0] a;
		input [11:0] ofs;
		begin
			isReg = (a == ofs);
		end
	endfunction

	// Lowest index trap wins; class A before class B by numbering
	// Bit two of the result says a trap is waiting
	function [2:0] trapPick;
		input [`IPC_NTRAP-1:0] p;
		integer j;
		begin
			trapPick = 3'h0;
			for (j = `IPC_NTRAP - 1; j >= 0; j = j - 1) begin
				if (p[j]) begin
					trapPick = {1'b1, j[1:0]};
				end
			end
		end
	endfunction

	// ****************************************
	// Vector helpers
	// ****************************************
	// Source i sits at trap number base plus i
	function [8:0] srcVec;
		input [2:0] idx;
		begin
			srcVec = {`IPC_SRC_TNUM_BASE + {4'h0, idx}, 2'b00};
		end
	endfunction

	// A vector is the trap number in word steps
	function [8:0] trapVec;
		input [1:0] t;
		begin
			trapVec = {trapNum(t), 2'b00};
		end
	endfunction

	// ****************************************
	// Arbitration of standard sources
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < `IPC_NSRC; g = g + 1) begin : gPack
			assign ctlFlat[8*g +: 8] = ctl_r[g];
		end
	endgenerate

	// The CPU level is compared live, so raising it withdraws an unacknowledged request
	ipc_arb uArb (
		.ctlFlat(ctlFlat),
		.cpuLevel(cpuLevel),
		.winValid(winValid),
		.winIdx(winIdx)
	);

	always @* begin
		{trapValid, trapSel} = trapPick(trapPend_r);
		trapRank = rankOf(trapSel);
	end

	// ****************************************
	// APB slave
	// ****************************************
	// One wait state: pready rises in the second access cycle
	// Writes to read-only registers complete and change nothing
	assign apbDone = psel && penable && pready;
	assign wrDone = apbDone && pwrite && !pslverr;
	assign ackInt = cpuAck && cpuReq && !cpuIsTrap;
	assign ackTrap = cpuAck && cpuReq && cpuIsTrap;

	// ****************************************
	// Register decoding
	// ****************************************
	// Strobes qualify on the completing edge only, so a stalled setup changes nothing
	wire [2:0] ctlSel;
	wire rdCtl;
	wire wrTrapFlag;
	wire wrEvClr;
	wire wrEvEn;
	// The state word is a read-only view of the presentation
	wire [31:0] stateWord;
	assign ctlSel = paddr[4:2];
	assign rdCtl = isCtl(paddr);
	assign wrTrapFlag = wrDone && isReg(paddr, `IPC_OFS_TRAPFLAG);
	assign wrEvClr = wrDone && isReg(paddr, `IPC_OFS_EVCLR);
	assign wrEvEn = wrDone && isReg(paddr, `IPC_OFS_EVEN);
	assign stateWord = {19'h00000, inTrapRank_r, cpuIsTrap, cpuReq, cpuVector};

	always @* begin
		rdMux = 32'h00000000;
		rdErr = 1'b0;
		if (rdCtl) begin
			rdMux = {24'h000000, ctl_r[ctlSel]};
		end else begin
			case (paddr)
				`IPC_OFS_TRAPFLAG: rdMux = {28'h0000000, trapFlag_r};
				`IPC_OFS_EVSTAT: rdMux = {29'h00000000, evStat_r};
				`IPC_OFS_EVCLR: rdMux = 32'h00000000;
				`IPC_OFS_EVEN: rdMux = {29'h00000000, evEn_r};
				`IPC_OFS_STATE: rdMux = stateWord;
				default: rdErr = 1'b1;
			endcase
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h00000000 : rdMux;
			pslverr <= rdErr;
		end else begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
	end

	// ****************************************
	// Source control registers
	// ****************************************
	generate
		for (g = 0; g < `IPC_NSRC; g = g + 1) begin : gCtl
			wire wrHit;
			wire ackHit;
			// Writing the pending flag high raises a request by software
			assign wrHit = wrDone && rdCtl && (ctlSel == g);
			assign ackHit = ackInt && (presIdx_r == g);
			always @(posedge clk) begin
				if (rst) begin
					ctl_r[g] <= `IPC_CTL_RST;
				end else begin
					// Bits above the low byte of the write word are dropped
					if (wrHit) begin
						ctl_r[g] <= pwdata[7:0];
					end else if (ackHit) begin
						ctl_r[g][`IPC_CTL_IR] <= 1'b0;
					end
					// A new request wins over a clear in the same cycle
					if (srcReq[g]) begin
						ctl_r[g][`IPC_CTL_IR] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Hardware traps
	// ****************************************
	// Write one to clear; an arriving trap wins over its clear
	// Write data above the trap bits is dropped
	wire [`IPC_NTRAP-1:0] trapFlag_nxt;
	wire [`IPC_NTRAP-1:0] trapPend_nxt;
	generate
		for (g = 0; g < `IPC_NTRAP; g = g + 1) begin : gTrap
			assign trapFlag_nxt[g] = trapIn[g] | (trapFlag_r[g] & ~(wrTrapFlag & pwdata[g]));
			assign trapPend_nxt[g] = trapIn[g] | (trapPend_r[g] & ~(ackTrap && presTrap_r == g));
		end
	endgenerate

	always @(posedge clk) begin
		if (rst) begin
			trapPend_r <= 4'h0;
			trapFlag_r <= 4'h0;
			inTrapRank_r <= `IPC_RANK_NONE;
		end else begin
			trapFlag_r <= trapFlag_nxt;
			trapPend_r <= trapPend_nxt;
			// Only one level is tracked; a nested trap return drops to none
			if (ackTrap) begin
				inTrapRank_r <= rankOf(presTrap_r);
			end else if (cpuTrapDone) begin
				inTrapRank_r <= `IPC_RANK_NONE;
			end
		end
	end

	// ****************************************
	// CPU request
	// ****************************************
	// A trap needs only a rank above the one in service
	wire trapWins;
	// Standard requests wait until no trap is in service
	wire intWins;
	assign trapWins = trapValid && (trapRank > inTrapRank_r);
	assign intWins = winValid && (inTrapRank_r == `IPC_RANK_NONE);

	// A better request may replace the vector before the ack; the ack takes what stands
	always @(posedge clk) begin
		if (rst) begin
			cpuReq <= 1'b0;
			cpuIsTrap <= 1'b0;
			cpuVector <= 9'h000;
			presIdx_r <= 3'h0;
			presTrap_r <= 2'h0;
		end else if (cpuAck && cpuReq) begin
			// Gap cycle lets the cleared flag settle before rearbitration
			cpuReq <= 1'b0;
		end else if (trapWins) begin
			// Traps ignore enables and CPU level
			cpuReq <= 1'b1;
			cpuIsTrap <= 1'b1;
			presTrap_r <= trapSel;
			cpuVector <= trapVec(trapSel);
		end else if (intWins) begin
			cpuReq <= 1'b1;
			cpuIsTrap <= 1'b0;
			presIdx_r <= winIdx;
			cpuVector <= srcVec(winIdx);
		end else begin
			cpuReq <= 1'b0;
			cpuIsTrap <= 1'b0;
		end
	end

	// ****************************************
	// Event status and interrupt output
	// ****************************************
	always @* begin
		evSet = 3'h0;
		evSet[`IPC_EV_INTACK] = ackInt;
		evSet[`IPC_EV_TRAPACK] = ackTrap;
		evSet[`IPC_EV_TRAPFLAG] = |trapIn;
	end

	// Set wins over a clear that lands in the same cycle
	wire [`IPC_NEV-1:0] evStat_nxt;
	generate
		for (g = 0; g < `IPC_NEV; g = g + 1) begin : gEv
			assign evStat_nxt[g] = evSet[g] | (evStat_r[g] & ~(wrEvClr & pwdata[g]));
		end
	endgenerate

	// irq lags the status by one cycle
	always @(posedge clk) begin
		if (rst) begin
			evStat_r <= 3'h0;
			evEn_r <= 3'h0;
			irq <= 1'b0;
		end else begin
			evStat_r <= evStat_nxt;
			if (wrEvEn) begin
				evEn_r <= pwdata[2:0];
			end
			irq <= |(evStat_r & evEn_r);
		end
	end
endmodule
`default_nettype wire

/* ipc_cpu_model.sv */
// Purpose: CPU core model answering the request handshake.
// Assumes: Same clock as the block.
// Notes: Slow mode delays the ack; a trap service lasts eight cycles.
`timescale 1ns/100ps
`default_nettype none
module ipc_cpu_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic cpuReq,
	input wire logic cpuIsTrap,
	output var logic cpuAck = 1'b0,
	output var logic cpuTrapDone = 1'b0
);
	logic [3:0] waitCnt_r = 4'h0;
	logic [3:0] trapCnt_r = 4'h0;
	always @(posedge clk) begin
		cpuAck <= 1'b0;
		cpuTrapDone <= trapCnt_r == 4'h1;
		waitCnt_r <= 4'h0;
		if (trapCnt_r != 4'h0)
			trapCnt_r <= trapCnt_r - 4'h1;
		if (rst)
			trapCnt_r <= 4'h0;
		else if (cpuReq && !cpuAck && waitCnt_r >= (slow ? 4'h6 : 4'h2)) begin
			cpuAck <= 1'b1;
			if (cpuIsTrap)
				trapCnt_r <= 4'h8;
		end else if (cpuReq && !cpuAck)
			waitCnt_r <= waitCnt_r + 4'h1;
	end
endmodule
`default_nettype wire

/* ipc_assertions.sv */
// Purpose: Port checks for ipc_top.
// Assumes: One clock, sync reset.
// Notes: Trap service is tracked from the handshake, not from state.
`timescale 1ns/100ps
`default_nettype none
module ipc_assertions (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] trapIn,
	input wire logic cpuAck,
	input wire logic cpuTrapDone,
	input wire logic cpuReq,
	input wire logic cpuIsTrap,
	input wire logic [8:0] cpuVector
);
	logic inTrap_r;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	always @(posedge clk)
		if (rst)
			inTrap_r <= 1'b0;
		else if (cpuReq && cpuAck && cpuIsTrap)
			inTrap_r <= 1'b1;
		else if (cpuTrapDone)
			inTrap_r <= 1'b0;
	a_upper_zero: assert property (pready && !pwrite && paddr < 12'h020 |-> prdata[31:8] == 0)
		else $error("upper bits set");
	a_unmapped_err: assert property (psel && penable && pready && paddr > 12'h030 |-> pslverr)
		else $error("no error on unmapped");
	a_src_vector: assert property (cpuReq && !cpuIsTrap |-> cpuVector inside {[9'h040:9'h05c]})
		else $error("bad source vector");
	a_trap_vector: assert property (cpuReq && cpuIsTrap |-> cpuVector inside {8, 16, 24, 40})
		else $error("bad trap vector");
	a_trap_only: assert property (inTrap_r && cpuReq |-> cpuIsTrap)
		else $error("interrupt in trap");
	a_trap_prompt: assert property (trapIn != 0 && !inTrap_r && !cpuReq |-> ##[1:4] cpuIsTrap)
		else $error("trap late");
	a_req_hold: assert property (cpuReq && !cpuAck |=> cpuReq)
		else $error("request dropped");
	a_idle_gap: assert property (cpuReq && cpuAck |=> !cpuReq)
		else $error("no idle gap");
endmodule
bind ipc_top ipc_assertions chk_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.trapIn(trapIn), .cpuAck(cpuAck), .cpuTrapDone(cpuTrapDone), .cpuReq(cpuReq),
	.cpuIsTrap(cpuIsTrap), .cpuVector(cpuVector));
`default_nettype wire

/* interrupt_priority_control_tb.sv */
// Purpose: Self-checking bench for ipc_top.
// Assumes: CPU side played by ipc_cpu_model.
// Notes: Random priorities from a fixed xorshift seed.
`timescale 1ns/100ps
`default_nettype none
module interrupt_priority_control_tb;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, slow = 0, errv;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdv, st = 67;
	logic pready, pslverr, cpuAck, cpuTrapDone, cpuReq, cpuIsTrap, irq;
	logic [7:0] srcReq = 0;
	logic [3:0] trapIn = 0, cpuLevel = 0;
	logic [8:0] cpuVector;
	logic [8:0] vq [$];
	logic [5:0] key [8];
	logic [8:0] tv [4] = '{9'h008, 9'h010, 9'h018, 9'h028};
	int miscompares = 0, cmp_count = 0;
	always #12.5 clk = ~clk;
	ipc_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.srcReq(srcReq), .trapIn(trapIn), .cpuLevel(cpuLevel), .cpuAck(cpuAck),
		.cpuTrapDone(cpuTrapDone), .cpuReq(cpuReq), .cpuIsTrap(cpuIsTrap),
		.cpuVector(cpuVector), .irq(irq));
	ipc_cpu_model cpu_u (.clk(clk), .rst(rst), .slow(slow), .cpuReq(cpuReq),
		.cpuIsTrap(cpuIsTrap), .cpuAck(cpuAck), .cpuTrapDone(cpuTrapDone));
	always @(posedge clk) if (cpuReq && cpuAck) vq.push_back(cpuVector);
	function logic [31:0] rnd();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction
	// Higher six-bit key wins; a tie keeps the lowest index
	function int best(logic [7:0] m);
		int b;
		b = -1;
		for (int i = 7; i >= 0; i--)
			if (m[i] && key[i][5:2] > cpuLevel && (b < 0 || key[i] >= key[b])) b = i;
		return b;
	endfunction
	task chk(string nm, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	// Idle edge first, so a release never meets the next request in one step
	task apb(logic w, logic [11:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1 && ++n < 40);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 40) miscompares++;
	endtask
	task rd(logic [11:0] a, logic [31:0] e);
		apb(0, a, 0);
		chk($sformatf("reg %h", a), e, rdv);
	endtask
	task pulse(logic [7:0] s, logic [3:0] t);
		@(posedge clk);
		srcReq <= s;
		trapIn <= t;
		@(posedge clk);
		srcReq <= 0;
		trapIn <= 0;
	endtask
	task waitq(int n);
		int k;
		k = 0;
		while (vq.size() < n && k++ < 300) @(posedge clk);
	endtask
	task stop_test();
		if (miscompares == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#1000000;
		miscompares++;
		stop_test();
	end
	initial begin
		logic [31:0] r;
		logic [7:0] pend;
		int e;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) rd(12'(4 * i), 0);
		apb(0, 12'h040, 0);
		chk("pslverr", 1, errv);
		for (int i = 0; i < 8; i++) begin
			r = rnd() & 32'hffffffbf;
			apb(1, 12'(4 * i), r);
			rd(12'(4 * i), r & 32'hff);
		end
		chk("cpuReq", 0, cpuReq);
		for (int w = 0; w < 3; w++) begin
			slow <= w[0];
			vq.delete();
			for (int i = 0; i < 8; i++) begin
				key[i] = 6'(rnd() % 60 + 4);
				apb(1, 12'(4 * i), {26'h0, key[i]} | 32'h40);
			end
			pulse(8'hff, 0);
			waitq(8);
			pend = 8'hff;
			for (int i = 0; i < 8; i++) begin
				e = best(pend);
				pend[e] = 1'b0;
				chk("vector", 9'h40 + 4 * e, vq[i]);
			end
		end
		cpuLevel <= 4'h8;
		vq.delete();
		apb(1, 0, 32'h60);
		apb(1, 4, 32'h64);
		pulse(8'h03, 0);
		waitq(2);
		rd(0, 32'he0);
		chk("vector", 9'h044, vq[0]);
		cpuLevel <= 4'h0;
		waitq(2);
		chk("vector", 9'h040, vq[1]);
		rd(0, 32'h60);
		apb(1, 12'h02c, 1);
		repeat (2) @(posedge clk);
		chk("irq", 1, irq);
		rd(12'h024, 1);
		apb(1, 12'h02c, 0);
		repeat (2) @(posedge clk);
		chk("irq", 0, irq);
		apb(1, 12'h02c, 1);
		apb(1, 12'h028, 1);
		apb(0, 12'h024, 0);
		chk("irq", 0, irq);
		chk("evstat", 0, rdv);
		for (int i = 0; i < 4; i++) begin
			vq.delete();
			pulse(0, 4'(1 << i));
			waitq(1);
			chk("trapvec", tv[i], vq[0]);
			repeat (12) @(posedge clk);
		end
		rd(12'h020, 32'hf);
		apb(1, 12'h020, 32'hf);
		rd(12'h020, 0);
		apb(1, 0, 32'h44);
		vq.delete();
		pulse(0, 4'h8);
		waitq(1);
		pulse(8'h01, 4'h1);
		waitq(3);
		chk("trapvec", 9'h008, vq[1]);
		chk("vector", 9'h040, vq[2]);
		rd(12'h030, 32'h040);
		stop_test();
	end
endmodule
`default_nettype wire
